// >>> shared/lfp_defs.vh
`ifndef LFP_DEFS_VH
`define LFP_DEFS_VH
// APB register byte offsets and the lock register reset value.
`define LFP_REG_LOCK 8'h00
`define LFP_REG_STATUS 8'h04
`define LFP_LOCK_RST 11'h000
// STATUS fields.
`define LFP_ST_MODE 0
`define LFP_ST_RST 1
`define LFP_ST_ERR 2
`define LFP_ST_WP 3
`define LFP_ST_TOPLOCK 4
`define LFP_ST_ID_LO 8
`define LFP_ST_INPUTS_LO 12
`define LFP_ST_CMD_LO 20
// LPC nibble codes.
`define LFP_START 4'h0
`define LFP_TYPE_MEM 2'b01
`define LFP_SYNC_OK 4'h0
`define LFP_TAR_IDLE 4'hf
`define LFP_ADDR_NIBS 4'h8
// Address 31:0 fields.
`define LFP_SEL_HI 25
`define LFP_SEL_LO 22
`define LFP_REGSPACE 21
`define LFP_ARRAY_W 19
// Sector map: seven 64 KB sectors then four 16 KB sectors; 10 is top.
`define LFP_TOP_SECTOR 4'ha
`define LFP_SECTORS 11
// Command codes.
`define LFP_CMD_READ 8'hff
`define LFP_CMD_PROG 8'h40
`define LFP_CMD_PROG2 8'h10
`define LFP_CMD_ERASE 8'h20
`define LFP_CMD_CONFIRM 8'hd0
`define LFP_CMD_STATUS 8'h70
`define LFP_CMD_CLRST 8'h50
`endif

// >>> core/lfp_top.v
// Functional notes
// - Strap high selects row/column programming port; low selects LPC.
// - Floating strap reads low via pull-down, selecting LPC.
// - Interface reset low blocks writes, resets automation, floats LAD in LPC.
// - Leaving reset enters read-array mode.
// - Processor reset and interface reset combine; either gives identical reset.
// - LFRAME low starts a transfer and aborts one in progress.
// - In LPC mode ID straps pull low, unconnected reads zero.
// - Programming mode offers only reads, byte program and sector erase; here it also takes the clear-status command.
// - Row/column select latches 11 address pins as row (low) or column.
// - LPC logic runs synchronous to the bus clock.
// - Full feature set, registers included, reachable only through LPC; here APB also reads STATUS and reads and writes the lock bits.
// - LPC memory reads and writes move one byte per transfer.
// - Both ports feed one command interpreter; only valid sequences start automation.
// - Array is eleven protectable, erasable sectors, four megabits total.
// - Top-sector lock low refuses program/erase of sector 10.
// - Write-protect low refuses program/erase of sectors 0 to 9.
// - Five general input levels readable through LPC registers.
// - Programming mode captures address and data on write strobe rising edge.
//
// Design decisions made here: the address map and the APB slave port.
`include "lfp_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module lfp_top (
   input wire clk,
   input wire rstn,
   input wire [7:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire interface_select_strap,
   input wire iface_rst_n,
   input wire proc_init_n,
   input wire [3:0] device_strap_id,
   input wire top_sector_lock_n,
   input wire write_protect_n,
   input wire [4:0] general_inputs,
   input wire lframe_n,
   input wire [3:0] lad_in,
   output reg [3:0] lad_out,
   output reg lad_oe,
   input wire [10:0] mux_addr,
   input wire mux_row_col,
   input wire mux_wr_n,
   input wire mux_oe_n,
   input wire [7:0] mux_io_in,
   output reg [7:0] mux_io_out,
   output reg mux_io_oe,
   input wire [7:0] array_rdata,
   input wire auto_busy,
   output reg [18:0] array_addr,
   output reg [7:0] prog_data,
   output reg prog_start,
   output reg erase_start,
   output reg auto_reset
);
   localparam S_IDLE = 8'h01;
   localparam S_TYPE = 8'h02;
   localparam S_ADDR = 8'h04;
   localparam S_WDAT = 8'h08;
   localparam S_TAR = 8'h10;
   localparam S_SYNC = 8'h20;
   localparam S_RDAT = 8'h40;
   localparam S_DONE = 8'h80;
   localparam C_READ = 4'h1;
   localparam C_PROG = 4'h2;
   localparam C_ERASE = 4'h4;
   localparam C_STAT = 4'h8;

   reg [7:0] st_ff, nxt_st;
   reg [3:0] cnt_ff, nxt_cnt;
   reg wr_ff, nxt_wr;
   reg [31:0] addr_ff, nxt_addr;
   reg [7:0] wdat_ff, nxt_wdat;
   reg mux_mode_ff, err_ff, mux_wr_n_ff;
   reg [10:0] lock_ff, row_ff;
   reg [3:0] cmd_ff, sector, nxt_lad;
   reg [7:0] col_ff, rd_byte, cmd_data;
   reg nxt_oe, prot, cmd_wr;
   reg [18:0] cmd_addr;

   wire in_reset = ~(iface_rst_n & proc_init_n);
   wire lpc_on = ~mux_mode_ff & ~in_reset;
   wire frame = lpc_on & ~lframe_n;
   wire id_hit = (addr_ff[`LFP_SEL_HI:`LFP_SEL_LO] == device_strap_id);
   wire reg_hit = ~addr_ff[`LFP_REGSPACE];
   wire [18:0] mux_full = {col_ff, row_ff};
   wire mux_wr_rise = mux_mode_ff & ~in_reset & mux_wr_n & ~mux_wr_n_ff;
   wire apb_acc = psel & penable & ~pready;
   wire apb_wr = apb_acc & pwrite;
   wire lock_sel = (paddr == `LFP_REG_LOCK);
   wire stat_sel = (paddr == `LFP_REG_STATUS);
   wire lpc_wr_done = (st_ff == S_SYNC) & wr_ff;
   wire lpc_reg_wr = lpc_wr_done & reg_hit;
   wire [31:0] status = {8'h00, cmd_ff, 3'b000, general_inputs, device_strap_id,
      3'b000, top_sector_lock_n, write_protect_n, err_ff, in_reset, mux_mode_ff};

   // LPC frame sequencer; a fresh start nibble under LFRAME wins over any state.
   always @* begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_wr = wr_ff;
      nxt_addr = addr_ff;
      nxt_wdat = wdat_ff;
      if (!lpc_on) begin
         nxt_st = S_IDLE;
      end else if (frame) begin
         nxt_st = (lad_in == `LFP_START) ? S_TYPE : S_IDLE;
         nxt_cnt = 4'h0;
      end else begin
         case (st_ff)
            S_TYPE: begin
               nxt_wr = lad_in[1];
               nxt_cnt = 4'h0;
               nxt_st = (lad_in[3:2] == `LFP_TYPE_MEM) ? S_ADDR : S_IDLE;
            end
            S_ADDR: begin
               nxt_addr = {addr_ff[27:0], lad_in};
               nxt_cnt = cnt_ff + 4'h1;
               if (cnt_ff == `LFP_ADDR_NIBS - 4'h1) begin
                  nxt_cnt = 4'h0;
                  nxt_st = wr_ff ? S_WDAT : S_TAR;
               end
            end
            S_WDAT: begin
               nxt_wdat = {lad_in, wdat_ff[7:4]};
               nxt_cnt = cnt_ff + 4'h1;
               if (cnt_ff[0]) begin
                  nxt_cnt = 4'h0;
                  nxt_st = S_TAR;
               end
            end
            S_TAR: begin
               nxt_cnt = cnt_ff + 4'h1;
               if (cnt_ff[0]) begin
                  nxt_cnt = 4'h0;
                  nxt_st = id_hit ? S_SYNC : S_IDLE;
               end
            end
            S_SYNC: begin
               nxt_st = wr_ff ? S_DONE : S_RDAT;
            end
            S_RDAT: begin
               nxt_cnt = cnt_ff + 4'h1;
               if (cnt_ff[0]) begin
                  nxt_cnt = 4'h0;
                  nxt_st = S_DONE;
               end
            end
            S_DONE: begin
               nxt_st = S_IDLE;
            end
            default: begin
               nxt_st = S_IDLE;
            end
         endcase
      end
   end

   // Register space answers only on LPC: it holds the general inputs and locks.
   always @* begin
      rd_byte = array_rdata;
      if (reg_hit) begin
         case (addr_ff[1:0])
            2'b00: rd_byte = {3'b000, general_inputs};
            2'b01: rd_byte = lock_ff[7:0];
            2'b10: rd_byte = {5'b00000, lock_ff[10:8]};
            default: rd_byte = 8'h00;
         endcase
      end else if (cmd_ff != C_READ) begin
         rd_byte = {~auto_busy, 1'b0, err_ff, 5'b00000};
      end
   end

   // LAD drive is registered from the next state so the pins change on clean edges.
   always @* begin
      nxt_oe = 1'b0;
      nxt_lad = `LFP_TAR_IDLE;
      case (nxt_st)
         S_SYNC: begin
            nxt_oe = 1'b1;
            nxt_lad = `LFP_SYNC_OK;
         end
         S_RDAT: begin
            nxt_oe = 1'b1;
            nxt_lad = nxt_cnt[0] ? rd_byte[7:4] : rd_byte[3:0];
         end
         S_DONE: begin
            nxt_oe = 1'b1;
         end
         default: begin
            nxt_oe = 1'b0;
         end
      endcase
   end

   // One interpreter for both ports; the row/column port never reaches registers.
   always @* begin
      cmd_wr = 1'b0;
      cmd_addr = addr_ff[18:0];
      cmd_data = wdat_ff;
      if (mux_wr_rise) begin
         cmd_wr = 1'b1;
         cmd_addr = mux_full;
         cmd_data = mux_io_in;
      end else if (lpc_wr_done & ~reg_hit) begin
         cmd_wr = 1'b1;
      end
   end

   // Eleven sectors: seven of 64 KB, the last 64 KB split into four of 16 KB.
   always @* begin
      sector = {1'b0, cmd_addr[18:16]};
      if (cmd_addr[18:16] == 3'b111) begin
         sector = 4'h7 + {2'b00, cmd_addr[15:14]};
      end
      if (sector == `LFP_TOP_SECTOR) begin
         prot = ~top_sector_lock_n | lock_ff[sector];
      end else begin
         prot = ~write_protect_n | lock_ff[sector];
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= S_IDLE;
         cnt_ff <= 4'h0;
         wr_ff <= 1'b0;
         addr_ff <= 32'h00000000;
         wdat_ff <= 8'h00;
         lad_out <= 4'hf;
         lad_oe <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         wr_ff <= nxt_wr;
         addr_ff <= nxt_addr;
         wdat_ff <= nxt_wdat;
         lad_out <= nxt_lad;
         lad_oe <= nxt_oe;
      end
   end

   // The strap is caught while reset is held, never sampled afterwards.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mux_mode_ff <= 1'b0;
         auto_reset <= 1'b1;
      end else begin
         if (in_reset) begin
            mux_mode_ff <= interface_select_strap;
         end
         auto_reset <= in_reset;
      end
   end

   // Row/column port: address halves latched by the select level, read gated by OE.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         row_ff <= 11'h000;
         col_ff <= 8'h00;
         mux_wr_n_ff <= 1'b1;
         mux_io_out <= 8'h00;
         mux_io_oe <= 1'b0;
      end else begin
         mux_wr_n_ff <= mux_wr_n;
         if (mux_mode_ff & mux_wr_n) begin
            if (mux_row_col) begin
               col_ff <= mux_addr[7:0];
            end else begin
               row_ff <= mux_addr;
            end
         end
         mux_io_oe <= mux_mode_ff & ~in_reset & ~mux_oe_n & mux_wr_n;
         mux_io_out <= (cmd_ff == C_READ) ? array_rdata : {~auto_busy, 1'b0, err_ff, 5'b00000};
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         array_addr <= 19'h00000;
      end else if (mux_mode_ff) begin
         array_addr <= mux_full;
      end else begin
         array_addr <= nxt_addr[18:0];
      end
   end

   // Command interpreter; an error seen in the clearing cycle stays set.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cmd_ff <= C_READ;
         err_ff <= 1'b0;
         prog_start <= 1'b0;
         erase_start <= 1'b0;
         prog_data <= 8'h00;
      end else begin
         prog_start <= 1'b0;
         erase_start <= 1'b0;
         if (in_reset) begin
            cmd_ff <= C_READ;
         end else if (cmd_wr & ~auto_busy) begin
            case (cmd_ff)
               C_PROG: begin
                  cmd_ff <= C_STAT;
                  prog_data <= cmd_data;
                  prog_start <= ~prot;
               end
               C_ERASE: begin
                  cmd_ff <= C_STAT;
                  erase_start <= ~prot & (cmd_data == `LFP_CMD_CONFIRM);
               end
               default: begin
                  case (cmd_data)
                     `LFP_CMD_PROG, `LFP_CMD_PROG2: cmd_ff <= C_PROG;
                     `LFP_CMD_ERASE: cmd_ff <= C_ERASE;
                     `LFP_CMD_STATUS: cmd_ff <= C_STAT;
                     `LFP_CMD_CLRST: cmd_ff <= C_STAT;
                     default: cmd_ff <= C_READ;
                  endcase
               end
            endcase
         end
         if (cmd_wr & ~auto_busy & ~in_reset & (cmd_ff == C_PROG || cmd_ff == C_ERASE) &
            (prot | (cmd_ff == C_ERASE && cmd_data != `LFP_CMD_CONFIRM))) begin
            err_ff <= 1'b1;
         end else if ((cmd_wr & ~in_reset & cmd_ff != C_PROG & cmd_ff != C_ERASE &
            cmd_data == `LFP_CMD_CLRST) | (apb_wr & stat_sel & pwdata[`LFP_ST_ERR])) begin
            err_ff <= 1'b0;
         end
      end
   end

   // Lock bits: LPC register writes take priority over APB in the same cycle.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lock_ff <= `LFP_LOCK_RST;
      end else if (lpc_reg_wr & addr_ff[1:0] == 2'b01) begin
         lock_ff[7:0] <= wdat_ff;
      end else if (lpc_reg_wr & addr_ff[1:0] == 2'b10) begin
         lock_ff[10:8] <= wdat_ff[2:0];
      end else if (apb_wr & lock_sel) begin
         lock_ff <= pwdata[10:0];
      end
   end

   // APB slave: one wait state, error on any address outside the two words.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= apb_acc;
         pslverr <= apb_acc & ~lock_sel & ~stat_sel;
         prdata <= 32'h00000000;
         if (apb_acc & ~pwrite & lock_sel) begin
            prdata <= {21'h00000, lock_ff};
         end else if (apb_acc & ~pwrite & stat_sel) begin
            prdata <= status;
         end
      end
   end
endmodule
`default_nettype wire

// >>> verif/lfp_props_properties.sv
`timescale 1ns/10ps
`default_nettype none
module lfp_props (
   input wire logic clk,
   input wire logic rstn,
   input wire logic interface_select_strap,
   input wire logic iface_rst_n,
   input wire logic proc_init_n,
   input wire logic top_sector_lock_n,
   input wire logic write_protect_n,
   input wire logic lad_oe,
   input wire logic mux_io_oe,
   input wire logic [18:0] array_addr,
   input wire logic prog_start,
   input wire logic erase_start,
   input wire logic auto_reset
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // The strap only moves under a pin reset, so outside one the mode is settled.
   mode_lpc_a: assert property (interface_select_strap |-> !lad_oe)
      else $error("LAD driven in mux mode");
   mode_mux_a: assert property (!interface_select_strap |-> !mux_io_oe)
      else $error("mux data driven in LPC mode");
   rst_float_a: assert property (!iface_rst_n |=> !lad_oe && auto_reset)
      else $error("reset pin did not float LAD");
   init_float_a: assert property (!proc_init_n |=> !lad_oe && auto_reset)
      else $error("init pin did not float LAD");
   rst_no_write_a: assert property (
      !iface_rst_n [*2] |-> !prog_start && !erase_start)
      else $error("automation started in reset");
   init_no_write_a: assert property (
      !proc_init_n [*2] |-> !prog_start && !erase_start)
      else $error("automation started in init");
   prot_pins_a: assert property (
      (prog_start || erase_start) |->
      ((&array_addr[18:14]) ? top_sector_lock_n : write_protect_n))
      else $error("protected sector written");
   start_excl_a: assert property (prog_start |-> !erase_start ##1 !prog_start)
      else $error("bad start pulse");
endmodule
bind lfp_top lfp_props u_lfp_props (.*);
`default_nettype wire

// >>> verif/lfp_lpc_host.sv
`timescale 1ns/10ps
`default_nettype none
module lfp_lpc_host (
   input wire logic clk,
   input wire logic [3:0] lad_bus,
   output logic lframe_n,
   output logic [3:0] lad_in
);
   // Idle and turnaround drive all ones, the level the LAD pull-ups give.
   initial begin
      lframe_n = 1'b1;
      lad_in = 4'hf;
   end
   task automatic cycle(input logic wr, input logic [31:0] a, input logic [7:0] d,
      input int nab, output logic ok, output logic [7:0] rd);
      ok = 1'b0;
      rd = 8'h00;
      @(posedge clk);
      lframe_n <= 1'b0;
      lad_in <= 4'h0;
      @(posedge clk);
      lframe_n <= 1'b1;
      lad_in <= {2'b01, wr, 1'b0};
      for (int i = 7; i >= 0; i--) begin
         @(posedge clk);
         if (7 - i == nab) begin
            lframe_n <= 1'b0;
            lad_in <= 4'hf;
            @(posedge clk);
            lframe_n <= 1'b1;
            // An ignored abort would still reach sync; watch long enough to see it.
            repeat (12) begin
               @(posedge clk);
               ok = ok | (lad_bus === 4'h0);
            end
            return;
         end
         lad_in <= a[i*4 +: 4];
      end
      if (wr) for (int j = 0; j < 2; j++) begin
         @(posedge clk);
         lad_in <= d[j*4 +: 4];
      end
      @(posedge clk);
      lad_in <= 4'hf;
      @(posedge clk);
      for (int i = 0; i < 6 && !ok; i++) begin
         @(posedge clk);
         ok = (lad_bus === 4'h0);
      end
      if (ok && !wr) begin
         @(posedge clk);
         rd[3:0] = lad_bus;
         @(posedge clk);
         rd[7:4] = lad_bus;
      end
      repeat (2) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "lfp_defs.vh"
module tb_top;
   logic clk, rstn, psel, penable, pwrite, pready, pslverr, lframe_n, lad_oe, ok, e;
   logic interface_select_strap, iface_rst_n, proc_init_n, top_sector_lock_n, write_protect_n;
   logic mux_row_col, mux_wr_n, mux_oe_n, mux_io_oe, auto_busy, prog_start, erase_start;
   logic auto_reset;
   logic [3:0] device_strap_id, lad_in, lad_out, lad_bus;
   logic [4:0] general_inputs;
   logic [7:0] paddr, mux_io_in, mux_io_out, array_rdata, prog_data, p_data, rd;
   logic [10:0] mux_addr;
   logic [18:0] array_addr, p_addr, a;
   logic [25:0] aa;
   logic [31:0] pwdata, prdata, r, rnd, n0;
   logic [31:0] n_pulse = 0;
   int err_count = 0;
   int checks_done = 0;
   int cyc = 0;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] arr_byte(input logic [18:0] x);
      return x[7:0] ^ x[15:8] ^ {5'h00, x[18:16]};
   endfunction
   function automatic logic [31:0] exp_status();
      return {8'h00, 4'h1, 3'h0, general_inputs, device_strap_id, 3'h0, top_sector_lock_n,
         write_protect_n, 2'b00, interface_select_strap};
   endfunction
   assign lad_bus = lad_oe ? lad_out : lad_in;
   assign array_rdata = arr_byte(array_addr);
   lfp_top u_lfp_top (.*);
   lfp_lpc_host u_lfp_lpc_host (.*);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Each run takes under two thousand cycles; a hang is cut off well above that.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         err_count++;
         final_report();
      end
      if (prog_start || erase_start) begin
         n_pulse <= n_pulse + 1;
         p_addr <= array_addr;
         p_data <= prog_data;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic lpc(input logic w, input logic [25:0] ad, input logic [7:0] d, input int nab);
      u_lfp_lpc_host.cycle(w, {6'h00, ad}, d, nab, ok, rd);
      repeat (3) @(posedge clk);
   endtask
   task automatic mux(input logic [10:0] row, input logic [7:0] col, input logic [7:0] d,
      input logic rdo);
      @(posedge clk);
      mux_row_col <= 1'b0;
      mux_addr <= row;
      @(posedge clk);
      mux_row_col <= 1'b1;
      mux_addr <= {3'h0, col};
      @(posedge clk);
      mux_io_in <= d;
      if (rdo) mux_oe_n <= 1'b0;
      else mux_wr_n <= 1'b0;
      @(posedge clk);
      mux_wr_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   initial begin
      {rstn, psel, penable, pwrite, paddr, pwdata, mux_row_col, mux_addr, mux_io_in} = '0;
      {iface_rst_n, proc_init_n, interface_select_strap, auto_busy} = '0;
      {top_sector_lock_n, write_protect_n, mux_wr_n, mux_oe_n} = '1;
      device_strap_id = 4'h0;
      general_inputs = 5'h00;
      rnd = 32'hf025987a;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      apb(0, `LFP_REG_STATUS, 0);
      chk(r[1], 1'b1);
      chk({lad_oe, auto_reset}, 2'b01);
      iface_rst_n <= 1'b1;
      proc_init_n <= 1'b1;
      apb(0, `LFP_REG_LOCK, 0);
      chk(r, {21'h0, `LFP_LOCK_RST});
      $display("reset test done");
      for (int k = 0; k < 8; k++) begin
         rnd = lfsr(rnd);
         general_inputs <= rnd[4:0];
         a = rnd[30:12];
         aa = {7'b0000100, a};
         apb(1, `LFP_REG_LOCK, rnd);
         apb(0, `LFP_REG_STATUS, 0);
         chk(r & 32'h00f1ff1b, exp_status());
         apb(0, `LFP_REG_LOCK, 0);
         chk(r, {21'h0, rnd[10:0]});
         apb(0, {k[5:0], 2'b00} + 8'h08, 0);
         chk(e, 1'b1);
         lpc(0, 26'h1, 0, 8);
         chk(rd, rnd[7:0]);
         lpc(0, 26'h0, 0, 8);
         chk(rd, {3'h0, general_inputs});
         lpc(0, aa, 0, 8);
         chk({ok, rd}, {1'b1, arr_byte(a)});
      end
      apb(1, `LFP_REG_LOCK, 0);
      lpc(0, {7'b0001100, a}, 0, 8);
      chk(ok, 1'b0);
      lpc(0, aa, 0, 3);
      chk(ok, 1'b0);
      lpc(0, aa, 0, 8);
      chk(rd, arr_byte(a));
      $display("LPC read test done");
      for (int k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         write_protect_n <= k[1];
         top_sector_lock_n <= ~k[1];
         a = (k[0] ^ k[1]) ? {5'h1f, rnd[13:0]} : {1'b0, ~k[0], ~k[0], rnd[15:0]};
         n0 = n_pulse;
         lpc(1, {7'b0000100, a}, `LFP_CMD_PROG, 8);
         lpc(1, {7'b0000100, a}, rnd[23:16], 8);
         chk(n_pulse - n0, k[0]);
         if (k[0]) chk({p_addr, p_data}, {a, rnd[23:16]});
      end
      write_protect_n <= 1'b1;
      top_sector_lock_n <= 1'b1;
      aa = {7'b0000100, a};
      n0 = n_pulse;
      lpc(1, aa, `LFP_CMD_ERASE, 8);
      lpc(1, aa, `LFP_CMD_PROG2, 8);
      lpc(1, aa, `LFP_CMD_ERASE, 8);
      lpc(1, aa, `LFP_CMD_CONFIRM, 8);
      chk(n_pulse - n0, 1);
      n0 = n_pulse;
      auto_busy <= 1'b1;
      lpc(1, aa, `LFP_CMD_PROG, 8);
      lpc(1, aa, 8'h55, 8);
      auto_busy <= 1'b0;
      chk(n_pulse - n0, 0);
      lpc(1, aa, `LFP_CMD_READ, 8);
      $display("protect test done");
      for (int k = 0; k < 2; k++) begin
         n0 = n_pulse;
         lpc(1, aa, `LFP_CMD_PROG, 8);
         if (k == 0) iface_rst_n <= 1'b0;
         else proc_init_n <= 1'b0;
         lpc(1, aa, 8'h00, 8);
         lpc(0, aa, 0, 8);
         chk(ok, 1'b0);
         iface_rst_n <= 1'b1;
         proc_init_n <= 1'b1;
         lpc(0, aa, 0, 8);
         chk(n_pulse - n0, 0);
         chk(rd, arr_byte(a));
      end
      $display("pin reset test done");
      @(posedge clk);
      iface_rst_n <= 1'b0;
      interface_select_strap <= 1'b1;
      repeat (3) @(posedge clk);
      iface_rst_n <= 1'b1;
      apb(0, `LFP_REG_STATUS, 0);
      chk(r[0], 1'b1);
      lpc(0, aa, 0, 8);
      chk(ok, 1'b0);
      for (int k = 0; k < 2; k++) begin
         rnd = lfsr(rnd);
         n0 = n_pulse;
         mux(0, 0, k ? `LFP_CMD_ERASE : `LFP_CMD_PROG, 0);
         mux(rnd[10:0], rnd[18:11], k ? `LFP_CMD_CONFIRM : rnd[26:19], 0);
         chk(n_pulse - n0, 1);
         chk(p_addr, rnd[18:0]);
         if (!k) chk(p_data, rnd[26:19]);
      end
      mux(0, 0, `LFP_CMD_READ, 0);
      mux(rnd[10:0], rnd[18:11], 0, 1);
      chk({mux_io_oe, mux_io_out}, {1'b1, arr_byte(rnd[18:0])});
      $display("mux test done");
      final_report();
   end
endmodule
`default_nettype wire
